// ### src/dnl_reset_loader.sv
// Reset sequencer that copies the non-volatile store into the DAC register.
`timescale 1ns/10ps
`default_nettype none
module dnl_reset_loader
	import dnl_pkg::*;
#(
	parameter int LOAD_CNT = LOAD_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supply_ok,
	input wire logic gc_reset,
	input wire logic reg_wr,
	input wire dnl_word_s reg_wdata,
	input wire logic store_wr,
	input wire dnl_word_s store_wdata,
	output dnl_word_s dac_reg,
	output dnl_word_s store_rdata,
	output logic [CODE_W-1:0] dac_code,
	output logic out_enable,
	output logic [SEL_W-1:0] load_select,
	output logic loading,
	output logic ready
);
	// The countdown register is eight bits wide, so longer loads cannot be counted.
	if (LOAD_CNT < 1 || LOAD_CNT > 255)
	begin : g_bad_load_cnt
		$error("LOAD_CNT out of range");
	end

	dnl_state_e state;
	logic [7:0] cnt;
	logic supply_meta, supply_sync;
	dnl_word_s store;

	// The supply monitor comes from the analog domain, so it is synchronised first.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			supply_meta <= 1'b0;
			supply_sync <= 1'b0;
		end
		else
		begin
			supply_meta <= supply_ok;
			supply_sync <= supply_meta;
		end
	end

	// The store itself survives supply loss; only rst_n restores factory content.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			store <= FACTORY_WORD;
		else if (store_wr && state == DNL_RUN)
			store <= store_wdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= DNL_OFF;
			cnt <= 8'h0;
		end
		else if (!supply_sync)
		begin
			state <= DNL_OFF;
			cnt <= 8'h0;
		end
		else
		begin
			case (state)
				DNL_OFF:
				begin
					state <= DNL_LOAD;
					cnt <= 8'(LOAD_CNT - 1);
				end
				DNL_LOAD:
				begin
					if (cnt == 8'h0)
						state <= DNL_RUN;
					else
						cnt <= cnt - 8'h1;
				end
				DNL_RUN:
				begin
					if (gc_reset)
					begin
						state <= DNL_LOAD;
						cnt <= 8'(LOAD_CNT - 1);
					end
				end
				default:
					state <= DNL_OFF;
			endcase
		end
	end

	// The reload has priority, so a bus write that lands during the copy is lost.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dac_reg <= '0;
		else if (state == DNL_LOAD)
			dac_reg <= store;
		else if (state == DNL_RUN && reg_wr && !gc_reset)
			dac_reg <= reg_wdata;
	end

	// Output follows code/4096 of supply; the analog side scales the unsigned code.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dac_code <= '0;
			out_enable <= 1'b0;
			load_select <= SEL_NORMAL;
		end
		else if (state != DNL_RUN)
		begin
			dac_code <= '0;
			out_enable <= 1'b0;
			load_select <= SEL_NORMAL;
		end
		else
		begin
			dac_code <= dac_reg.code;
			out_enable <= {dac_reg.powerdown_select_hi, dac_reg.powerdown_select_lo} == SEL_NORMAL;
			load_select <= {dac_reg.powerdown_select_hi, dac_reg.powerdown_select_lo};
		end
	end

	assign store_rdata = store;
	assign loading = (state == DNL_LOAD);
	assign ready = (state == DNL_RUN);

	property p_load_copies;
		@(posedge clk) disable iff (!rst_n)
		(state == DNL_LOAD && supply_sync) |=> dac_reg == $past(store);
	endproperty
	a_load_copies: assert property (p_load_copies) else $error("store not copied");

	// A general call is taken in one cycle and the reload shows in the next.
	sequence s_running;
		ready;
	endsequence

	sequence s_gc_taken;
		ready && gc_reset && supply_sync;
	endsequence

	sequence s_reload;
		loading && !ready;
	endsequence

	property p_load_ends;
		@(posedge clk) disable iff (!rst_n)
		(loading && cnt == 8'h0 && supply_sync) |=> ready && dac_reg == $past(store);
	endproperty
	a_load_ends: assert property (p_load_ends) else $error("load did not finish");

	property p_no_out_low;
		@(posedge clk) disable iff (!rst_n)
		!supply_sync |=> ##1 !out_enable && dac_code == '0;
	endproperty
	a_no_out_low: assert property (p_no_out_low) else $error("output while supply low");

	property p_off_clear;
		@(posedge clk) disable iff (!rst_n)
		!supply_sync |=> !loading && !ready;
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("not off while supply low");

	property p_out_quiet;
		@(posedge clk) disable iff (!rst_n)
		!ready |=> !out_enable && dac_code == '0 && load_select == SEL_NORMAL;
	endproperty
	a_out_quiet: assert property (p_out_quiet) else $error("output outside run");

	property p_gc_loads;
		@(posedge clk) disable iff (!rst_n)
		s_gc_taken |=> s_reload;
	endproperty
	a_gc_loads: assert property (p_gc_loads) else $error("general call did not reset");

	property p_hold_writes;
		@(posedge clk) disable iff (!rst_n)
		(loading && reg_wr && supply_sync) |=> dac_reg == $past(store);
	endproperty
	a_hold_writes: assert property (p_hold_writes) else $error("bus write during load");

	property p_run_write;
		@(posedge clk) disable iff (!rst_n)
		(ready && reg_wr && !gc_reset && supply_sync) |=> dac_reg == $past(reg_wdata);
	endproperty
	a_run_write: assert property (p_run_write) else $error("register write lost");

	property p_store_refused;
		@(posedge clk) disable iff (!rst_n)
		(!ready && store_wr) |=> store_rdata == $past(store_rdata);
	endproperty
	a_store_refused: assert property (p_store_refused) else $error("store written outside run");

	property p_mode;
		@(posedge clk) disable iff (!rst_n)
		s_running |=> out_enable ==
			($past({dac_reg.powerdown_select_hi, dac_reg.powerdown_select_lo}) == SEL_NORMAL);
	endproperty
	a_mode: assert property (p_mode) else $error("mode select wrong");

	property p_code_out;
		@(posedge clk) disable iff (!rst_n)
		s_running |=> dac_code == $past(dac_reg.code);
	endproperty
	a_code_out: assert property (p_code_out) else $error("code not driven");

	property p_select;
		@(posedge clk) disable iff (!rst_n)
		s_running |=> load_select ==
			$past({dac_reg.powerdown_select_hi, dac_reg.powerdown_select_lo});
	endproperty
	a_select: assert property (p_select) else $error("load select wrong");
endmodule : dnl_reset_loader
`default_nettype wire

// ### src/dnl_pkg.sv
// Constants and carrier types for the DAC reset and non-volatile load logic.
// Behaviour
// - Store holds fourteen bits: two power-down select bits and a twelve-bit code.
// - At first power-on the code is loaded from the store and driven out.
// - Power-down select bits in the DAC register choose normal or power-down mode.
// - Code is unsigned binary; output equals code over 4096 of supply.
// - Reset is entered only on power-on reset or general call reset.
// - Every reset period copies the whole store into the DAC register.
// - Below the reset threshold everything is disabled and there is no output.
// - After power-on reset, register and store may be read anytime but rewritten only in DNL_RUN.
// - General call reset at stable supply presents the stored output once the load period ends.
// - Select bits: 00 normal, 01 1k, 10 100k, 11 500k load to ground.
// - Factory default store has only the code MSB set, giving mid-scale.
package dnl_pkg;
	localparam int CODE_W = 12;
	localparam int SEL_W = 2;
	localparam int STORE_W = SEL_W + CODE_W;
	localparam int FULL_SCALE = 4096;
	localparam logic [CODE_W-1:0] CODE_MSB = 12'h800;
	localparam logic [SEL_W-1:0] SEL_NORMAL = 2'h0;
	localparam logic [SEL_W-1:0] SEL_LOAD_1K = 2'h1;
	localparam logic [SEL_W-1:0] SEL_LOAD_100K = 2'h2;
	localparam logic [SEL_W-1:0] SEL_LOAD_500K = 2'h3;
	localparam int LOAD_TIME_NS = 300;
	localparam int CLK_PERIOD_NS = 100;
	localparam int LOAD_CYCLES = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic powerdown_select_hi;
		logic powerdown_select_lo;
		logic [CODE_W-1:0] code;
	} dnl_word_s;

	localparam dnl_word_s FACTORY_WORD = '{1'b0, 1'b0, CODE_MSB};

	typedef enum logic [1:0] {
		DNL_OFF = 2'h0,
		DNL_LOAD = 2'h1,
		DNL_RUN = 2'h3
	} dnl_state_e;
endpackage : dnl_pkg

// ### tb/dnl_master_model.sv
// Bus master stand-in that issues a general call reset.
`timescale 1ns/10ps
`default_nettype none
module dnl_master_model
(
	input wire logic clk,
	input wire logic req,
	input wire logic ready,
	output var logic gc_reset
);
	// A master only resets the device once it is up.
	always @(negedge clk)
	begin
		gc_reset <= req && ready;
	end
endmodule : dnl_master_model
`default_nettype wire

// ### tb/dnl_reset_loader_bench.sv
// Self-checking bench for the reset and store load logic.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) compares++; if ((s) !== (e)) begin miscompares++; \
	$display("wrong value %s exp %h got %h", n, e, s); end
module dnl_reset_loader_bench
	import dnl_pkg::*;
;
	logic clk = 0, rst_n = 0, supply_ok = 1, reg_wr = 0, store_wr = 0, req = 0;
	dnl_word_s reg_wdata = '0, store_wdata = '0, dac_reg, store_rdata;
	logic [CODE_W-1:0] dac_code;
	logic [SEL_W-1:0] load_select;
	logic gc_reset, out_enable, loading, ready;
	int miscompares = 0, compares = 0;
	localparam dnl_word_s SAVED = '{1'b0, 1'b1, 12'h123};
	always #50 clk = ~clk;
	dnl_reset_loader #(.LOAD_CNT(3)) i_dnl_reset_loader (.clk(clk), .rst_n(rst_n),
		.supply_ok(supply_ok), .gc_reset(gc_reset), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .store_wr(store_wr), .store_wdata(store_wdata),
		.dac_reg(dac_reg), .store_rdata(store_rdata), .dac_code(dac_code),
		.out_enable(out_enable), .load_select(load_select), .loading(loading),
		.ready(ready));
	dnl_master_model i_dnl_master_model (.clk(clk), .req(req), .ready(ready),
		.gc_reset(gc_reset));
	task report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	task wait_ready(input logic lvl);
		int n;
		n = 0;
		while (ready !== lvl && n < 40)
		begin
			cyc(1);
			n++;
		end
		if (ready !== lvl)
		begin
			miscompares++;
			report_and_stop();
		end
	endtask : wait_ready
	task wr_reg(input dnl_word_s w);
		reg_wdata = w;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
		cyc(1);
	endtask : wr_reg
	task t_boot;
		wait_ready(1);
		`CHK("store", FACTORY_WORD, store_rdata)
		`CHK("reg", FACTORY_WORD, dac_reg)
		cyc(1);
		`CHK("code", CODE_MSB, dac_code)
		`CHK("oe", 1'b1, out_enable)
		$display("test boot done");
	endtask : t_boot
	task t_modes;
		for (int i = 0; i < 4; i++)
		begin
			wr_reg('{i[1], i[0], 12'hfff});
			`CHK("sel", 2'(i), load_select)
			`CHK("oe", i == 0, out_enable)
		end
		wr_reg('{1'b0, 1'b0, 12'ha5c});
		`CHK("code", 12'ha5c, dac_code)
		`CHK("oe", 1'b1, out_enable)
		$display("test modes done");
	endtask : t_modes
	task t_gc;
		store_wdata = SAVED;
		store_wr = 1;
		cyc(1);
		store_wr = 0;
		`CHK("store", SAVED, store_rdata)
		req <= 1;
		cyc(1);
		req <= 0;
		cyc(1);
		`CHK("loading", 1'b1, loading)
		store_wdata = '{1'b1, 1'b1, 12'hbad};
		store_wr = 1;
		wr_reg('{1'b0, 1'b0, 12'h456});
		store_wr = 0;
		wait_ready(1);
		`CHK("reg", SAVED, dac_reg)
		`CHK("store", SAVED, store_rdata)
		cyc(1);
		`CHK("sel", 2'h1, load_select)
		`CHK("code", 12'h123, dac_code)
		$display("test gc done");
	endtask : t_gc
	task t_supply;
		wr_reg('{1'b0, 1'b0, 12'hfff});
		supply_ok = 0;
		wait_ready(0);
		cyc(1);
		`CHK("oe", 1'b0, out_enable)
		`CHK("code", 12'h000, dac_code)
		supply_ok = 1;
		wait_ready(1);
		`CHK("reg", SAVED, dac_reg)
		$display("test supply done");
	endtask : t_supply
	initial
	begin
		cyc(12);
		rst_n = 1;
		t_boot();
		t_modes();
		t_gc();
		t_supply();
		report_and_stop();
	end
endmodule : dnl_reset_loader_bench
`default_nettype wire
